//--- ssfd_assertions.sv
// checker: bus handshakes and interrupt pulse of ssfd_top.
// assumes it is bound to ssfd_top and sees only its ports.
`timescale 1ns/100ps
module ssfd_assertions import ssfd_pkg::*; (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // aw addr
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // b resp
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic serial_irq // irq pulse
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_bad_wr;
    s_wr_both ##0 (s_axi_awaddr == 4'hc);
  endsequence
  property p_irq_pulse;
    serial_irq |=> !serial_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("b dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("r dropped");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write during b");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read during r");
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_wr_lat;
    s_wr_both |-> !s_axi_bvalid ##2 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("b timing");
  property p_bad_wr;
    s_bad_wr |-> ##2 (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  endproperty
  a_bad_wr: assert property (p_bad_wr) else $error("bad write ok");
endmodule : ssfd_assertions

bind ssfd_top ssfd_assertions u_chk (.*);

//--- ssfd_clkgen.sv
// serial clock source: internal divider or edges of the peer's clock.
// assumes the peer clock input is synchronous to aclk.
`timescale 1ns/100ps
module ssfd_clkgen import ssfd_pkg::*; (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, low active
  input wire logic ce, // clock enable
  input wire logic run, // clocking allowed
  input wire logic ext, // take peer clock
  input wire logic edge_sel, // edge choice
  input wire logic [2:0] sel, // internal rate
  input wire logic sclk_in, // peer clock level
  output logic sclk_out, // driven clock level
  output logic sample_p, // sample edge pulse
  output logic launch_p // launch edge pulse
);
  logic [15:0] cnt_q;
  logic sclk_q;
  logic prev_q;
  logic tick;
  logic rise;
  logic fall;

  assign tick = run && !ext && (cnt_q == 16'(ssfd_half(sel) - 16'h0001));

  // R6 internal clock at selected rate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 16'h0000;
      sclk_q <= 1'b1;
    end else if (ce) begin
      if (!run || ext) begin
        cnt_q <= 16'h0000;
        sclk_q <= ~edge_sel;
      end else if (tick) begin
        cnt_q <= 16'h0000;
        sclk_q <= ~sclk_q;
      end else begin
        cnt_q <= 16'(cnt_q + 16'h0001);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b1;
    end else if (ce) begin
      prev_q <= sclk_in;
    end
  end

  assign rise = ext ? (run && sclk_in && !prev_q) : (tick && !sclk_q);
  assign fall = ext ? (run && !sclk_in && prev_q) : (tick && sclk_q);
  // R24 edge choice
  assign sample_p = edge_sel ? fall : rise;
  assign launch_p = edge_sel ? rise : fall;
  assign sclk_out = sclk_q;

endmodule : ssfd_clkgen

//--- ssfd_peer.sv
// serial peer: msb first, launches on falling, samples on rising clock.
// assumes aclk-synchronous pins; makes the clock itself when oe is low.
`timescale 1ns/100ps
module ssfd_peer (
  input wire logic aclk, // system clock
  input wire logic sclk_o, // port clock out
  input wire logic sclk_oe, // port drives clock
  input wire logic so, // port data out
  input wire logic load, // take tx byte
  input wire logic [7:0] tx, // byte to send
  input wire logic go, // run eight clocks
  output logic sclk, // clock pin level
  output logic si, // data to port
  output logic [7:0] rx, // last eight bits seen
  output logic busy // own clock running
);
  logic ext_q = 1'b1;
  logic [3:0] div_q = 4'h0;
  logic [4:0] cnt_q = 5'h00;
  logic prev_q = 1'b1;
  logic [7:0] sh_q = 8'h00;
  initial si = 1'b1;
  initial rx = 8'h00;
  assign sclk = sclk_oe ? sclk_o : ext_q;
  assign busy = cnt_q != 5'h00;
  always @(posedge aclk) begin
    if (go) begin
      cnt_q <= 5'h10;
      div_q <= 4'h0;
    end else if (busy) begin
      div_q <= div_q + 4'h1;
      if (div_q == 4'h3) begin
        ext_q <= ~ext_q;
        cnt_q <= cnt_q - 5'h01;
        div_q <= 4'h0;
      end
    end
  end
  // released line shows inverted bits
  always @(posedge aclk) begin
    prev_q <= sclk;
    if (load) begin
      sh_q <= tx;
    end else if (prev_q && !sclk) begin
      si <= sh_q[7];
      sh_q <= {sh_q[6:0], ~sh_q[7]};
    end
    if (!prev_q && sclk) begin
      rx <= {rx[6:0], so};
    end
  end
endmodule : ssfd_peer

//--- ssfd_pkg.sv
// package for the full-duplex clocked serial port: register map, field layouts,
// states and shared helpers. assumes a 32-bit AXI4-Lite register bus.
package ssfd_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STAT = 4'h4;
  localparam logic [3:0] OFF_DATA = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // field layouts and reset values
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] clock_select_field;
    logic edge_select_field;
    logic bit_order_field;
    logic start_bit;
    logic [1:0] mode_field;
  } ssfd_ctrl_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic underrun_flag;
    logic overrun_flag;
    logic receive_complete_flag;
    logic buffer_full_flag;
    logic shift_active_flag;
    logic in_operation_flag;
  } ssfd_stat_t;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [1:0] MODE_OFF = 2'b00;
  localparam logic [1:0] MODE_FDX = 2'b11;
  localparam logic [2:0] CKS_EXT = 3'b111;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [15:0] HALF_BASE = 16'h0001;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_WAIT = 2'b10,
    ST_DRAIN = 2'b11
  } ssfd_state_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] ssfd_half(input logic [2:0] sel);
    return HALF_BASE << sel;
  endfunction : ssfd_half

  function automatic logic [7:0] ssfd_shift_in(input logic [7:0] sh, input logic msb, input logic bit_in);
    return msb ? {sh[6:0], bit_in} : {bit_in, sh[7:1]};
  endfunction : ssfd_shift_in

endpackage : ssfd_pkg

//--- ssfd_shifter.sv
// eight-bit shift register that launches and samples on given pulses.
// assumes a launch pulse precedes each sample pulse.
`timescale 1ns/100ps
module ssfd_shifter import ssfd_pkg::*; (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, low active
  input wire logic ce, // clock enable
  input wire logic load, // take a new byte
  input wire logic [7:0] load_data, // byte to send
  input wire logic msb_first, // bit order
  input wire logic launch, // drive next bit
  input wire logic sample, // take input bit
  input wire logic serial_in, // input pin level
  input wire logic force_high, // park output high
  output logic serial_out, // output pin level
  output logic [7:0] rx_byte, // byte at done
  output logic done // eighth bit taken
);
  logic [7:0] sh_q;
  logic [2:0] cnt_q;
  logic so_q;

  // R5 send and sample together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_q <= 8'h00;
      cnt_q <= 3'h0;
    end else if (ce) begin
      if (load) begin
        sh_q <= load_data;
        cnt_q <= 3'h0;
      end else if (sample) begin
        sh_q <= ssfd_shift_in(sh_q, msb_first, serial_in);
        cnt_q <= 3'(cnt_q + 3'h1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      so_q <= 1'b1;
    end else if (ce) begin
      if (force_high) begin
        so_q <= 1'b1;
      end else if (launch) begin
        // R24 bit order
        so_q <= msb_first ? sh_q[7] : sh_q[0];
      end
    end
  end

  assign done = sample && (cnt_q == BIT_LAST);
  assign rx_byte = ssfd_shift_in(sh_q, msb_first, serial_in);
  assign serial_out = so_q;

endmodule : ssfd_shifter

//--- ssfd_top.sv
// full-duplex eight-bit clocked serial port with an AXI4-Lite register slave.
// assumes serial pins are synchronous to aclk and the bus master is AXI4-Lite.
//
// Notes on behaviour
// R1: mode field value 11 selects full-duplex eight-bit transfer.
// R2: clock select value 111 takes the serial clock from the pin.
// R3: software loads the first byte before setting the start bit.
// R4: while operating only mode 00 or start 0 writes take effect.
// R5: start moves buffer to shifter; bits go out while bits come in.
// R6: internal clock is driven on the pin; external comes from the peer.
// R7: starting without a buffer write sends whatever the buffer holds.
// R8: start sets in-operation and shift-active and pulses the interrupt.
// R9: shift-active clears when the eighth bit is received; here it stays set at byte end on the external clock or with buffer-full set.
// R10: buffer write with empty shifter during operation loads at once.
// R11: buffer write with busy shifter sets buffer-full; next write replaces.
// R12: each byte end sets receive-complete and pulses the interrupt.
// R13: internal clock, buffer full at byte end: continue; overrun if unread.
// R14: internal clock, buffer empty at byte end: pause, output high.
// R15: external clock keeps going, resends old byte and flags underrun.
// R16: external clock, byte received while receive-complete set flags overrun.
// R17: start cleared while not shifting stops at once, no interrupt.
// R18: start cleared while shifting finishes the byte, stops, interrupts.
// R19: full stop clears in-operation, shift-active, buffer-full only.
// R20: after stop output goes high on internal clock, holds on external.
// R21: mode 00 forces stop, clears start and status, output high.
// R22: data read clears receive-complete; status read clears overrun.
// R23: status read clears the underrun flag.
// R24: bit order and edge fields pick shift direction and clock edges.
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
module ssfd_top import ssfd_pkg::*; (
  input wire logic aclk, // system clock, 10 MHz
  input wire logic aresetn, // sync reset, low active
  input wire logic ce, // clock enable
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic serial_clock_pin_i, // clock pin level in
  output logic serial_clock_pin_o, // clock pin level out
  output logic serial_clock_pin_oe, // clock pin drive enable
  input wire logic serial_in_pin, // serial data in
  output logic serial_out_pin, // serial data out
  output logic serial_irq // interrupt request pulse
);

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic aw_hold_q;
  logic w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic wr_fire;
  logic rd_fire;
  logic wr_ctrl;
  logic wr_data;
  logic rd_stat;
  logic rd_data;
  logic wr_hit;
  logic rd_hit;

  ssfd_ctrl_t ctrl_q;
  ssfd_stat_t stat_w;
  ssfd_ctrl_t ctrl_in;
  ssfd_state_t state_q;
  logic [7:0] tx_buf_q;
  logic [7:0] rx_buf_q;
  logic sef_q;
  logic buffer_full_flag_q;
  logic receive_complete_flag_q;
  logic overrun_flag_q;
  logic underrun_flag_q;
  logic reuse_q;
  logic irq_q;

  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q && ce;
  assign s_axi_arready = !rvalid_q;
  assign rd_fire = s_axi_arvalid && !rvalid_q && ce;
  assign wr_hit = (awaddr_q == OFF_CTRL) || (awaddr_q == OFF_STAT) || (awaddr_q == OFF_DATA);
  assign rd_hit = (s_axi_araddr == OFF_CTRL) || (s_axi_araddr == OFF_STAT) || (s_axi_araddr == OFF_DATA);
  assign wr_ctrl = wr_fire && wstrb_q[0] && (awaddr_q == OFF_CTRL);
  assign wr_data = wr_fire && wstrb_q[0] && (awaddr_q == OFF_DATA);
  assign rd_stat = rd_fire && (s_axi_araddr == OFF_STAT);
  assign rd_data = rd_fire && (s_axi_araddr == OFF_DATA);
  assign ctrl_in = ssfd_ctrl_t'(wdata_q[7:0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awaddr_q <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        case (s_axi_araddr)
          OFF_CTRL: rdata_q <= {24'h00_0000, ctrl_q};
          OFF_STAT: rdata_q <= {24'h00_0000, stat_w};
          OFF_DATA: rdata_q <= {24'h00_0000, rx_buf_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // ----------------------------------------------------------------
  // serial engine
  // ----------------------------------------------------------------
  logic in_op;
  logic shifting;
  logic ext_clk;
  logic run;
  logic sample_p;
  logic launch_p;
  logic done;
  logic [7:0] rx_byte;
  logic start_req;
  logic stop_req;
  logic force_off;
  logic load;
  logic [7:0] load_data;
  logic force_high;
  logic idle_stop;

  assign in_op = (state_q != ST_IDLE);
  assign shifting = (state_q == ST_SHIFT) || (state_q == ST_DRAIN);
  // R2 external clock select
  assign ext_clk = (ctrl_q.clock_select_field == CKS_EXT);
  assign run = shifting;
  // R21 mode 00 forces a stop
  assign force_off = wr_ctrl && (ctrl_in.mode_field == MODE_OFF);
  // R1 start only in full-duplex mode
  assign start_req = wr_ctrl && !in_op && ctrl_in.start_bit && (ctrl_in.mode_field == MODE_FDX);
  assign stop_req = wr_ctrl && in_op && !ctrl_in.start_bit && !force_off;
  assign idle_stop = stop_req && ((state_q == ST_WAIT) || (state_q == ST_SHIFT && reuse_q));
  // R10 immediate load into an empty shifter
  assign load = start_req || (done && state_q == ST_SHIFT) || (wr_data && state_q == ST_WAIT);
  assign load_data = (wr_data && state_q == ST_WAIT) ? wdata_q[7:0] : tx_buf_q;
  // R14 R20 output parks high
  assign force_high = force_off || (idle_stop && !ext_clk) || (done && !ext_clk && (state_q == ST_DRAIN || !buffer_full_flag_q));

  // R4 fields locked while operating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= ssfd_ctrl_t'(CTRL_RST);
    end else if (ce) begin
      if (wr_ctrl && !in_op) begin
        ctrl_q <= ctrl_in;
      end else if (force_off) begin
        ctrl_q.mode_field <= MODE_OFF;
        ctrl_q.start_bit <= 1'b0;
      end else if (stop_req) begin
        ctrl_q.start_bit <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
    end else if (ce) begin
      if (force_off) begin
        state_q <= ST_IDLE;
      end else begin
        case (state_q)
          ST_IDLE: begin
            // R5 start loads the shifter
            if (start_req) begin
              state_q <= ST_SHIFT;
            end
          end
          ST_SHIFT: begin
            // R17 R18 stop now or after the byte
            if (stop_req) begin
              state_q <= reuse_q ? ST_IDLE : ST_DRAIN;
            end else if (done && !ext_clk && !buffer_full_flag_q) begin
              state_q <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (stop_req) begin
              state_q <= ST_IDLE;
            end else if (wr_data) begin
              state_q <= ST_SHIFT;
            end
          end
          ST_DRAIN: begin
            if (done) begin
              state_q <= ST_IDLE;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // R11 buffer-full and overwrite
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_buf_q <= DATA_RST;
      buffer_full_flag_q <= 1'b0;
    end else if (ce) begin
      if (wr_data) begin
        tx_buf_q <= wdata_q[7:0];
      end
      if (force_off || idle_stop || (done && state_q == ST_DRAIN)) begin
        // R19 stop clears buffer-full
        buffer_full_flag_q <= 1'b0;
      end else if (wr_data && shifting) begin
        buffer_full_flag_q <= 1'b1;
      end else if (done && state_q == ST_SHIFT) begin
        // R13 continue with buffered byte
        buffer_full_flag_q <= 1'b0;
      end
    end
  end

  // R8 R9 shift-active tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sef_q <= 1'b0;
    end else if (ce) begin
      if (force_off || idle_stop) begin
        sef_q <= 1'b0;
      end else if (start_req || (wr_data && state_q == ST_WAIT)) begin
        sef_q <= 1'b1;
      end else if (done) begin
        sef_q <= (state_q == ST_SHIFT) && (ext_clk || buffer_full_flag_q);
      end
    end
  end

  // R12 R16 receive-complete and overrun
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_buf_q <= DATA_RST;
      receive_complete_flag_q <= 1'b0;
      overrun_flag_q <= 1'b0;
    end else if (ce) begin
      if (force_off) begin
        receive_complete_flag_q <= 1'b0;
        overrun_flag_q <= 1'b0;
      end else if (done) begin
        receive_complete_flag_q <= 1'b1;
        if (receive_complete_flag_q && !rd_data) begin
          // R13 keep the unread byte
          overrun_flag_q <= 1'b1;
        end else begin
          rx_buf_q <= rx_byte;
          // R22 status read clears overrun
          if (rd_stat) begin
            overrun_flag_q <= 1'b0;
          end
        end
      end else begin
        if (rd_data) begin
          receive_complete_flag_q <= 1'b0;
        end
        if (rd_stat) begin
          overrun_flag_q <= 1'b0;
        end
      end
    end
  end

  // R15 R23 resend and underrun
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reuse_q <= 1'b0;
      underrun_flag_q <= 1'b0;
    end else if (ce) begin
      if (force_off) begin
        reuse_q <= 1'b0;
        underrun_flag_q <= 1'b0;
      end else begin
        if (wr_data || start_req) begin
          reuse_q <= 1'b0;
        end else if (done && ext_clk && state_q == ST_SHIFT && !buffer_full_flag_q) begin
          reuse_q <= 1'b1;
        end else if (launch_p && reuse_q) begin
          reuse_q <= 1'b0;
        end
        if (launch_p && reuse_q && shifting) begin
          underrun_flag_q <= 1'b1;
        end else if (rd_stat) begin
          underrun_flag_q <= 1'b0;
        end
      end
    end
  end

  // R8 R12 R18 interrupt pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= (start_req || done) && !force_off;
    end else begin
      irq_q <= 1'b0;
    end
  end

  assign stat_w = ssfd_stat_t'({2'b00, underrun_flag_q, overrun_flag_q, receive_complete_flag_q, buffer_full_flag_q, sef_q, in_op});

  // ----------------------------------------------------------------
  // clock and shift units
  // ----------------------------------------------------------------
  ssfd_clkgen u_clkgen (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .run(run),
    .ext(ext_clk),
    .edge_sel(ctrl_q.edge_select_field),
    .sel(ctrl_q.clock_select_field),
    .sclk_in(serial_clock_pin_i),
    .sclk_out(serial_clock_pin_o),
    .sample_p(sample_p),
    .launch_p(launch_p)
  );

  // R7 buffer contents sent as they stand
  ssfd_shifter u_shifter (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .load(load),
    .load_data(load_data),
    .msb_first(ctrl_q.bit_order_field),
    .launch(launch_p && shifting),
    .sample(sample_p && shifting),
    .serial_in(serial_in_pin),
    .force_high(force_high),
    .serial_out(serial_out_pin),
    .rx_byte(rx_byte),
    .done(done)
  );

  // R6 drive the clock pin only for the internal clock
  assign serial_clock_pin_oe = !ext_clk && (ctrl_q.mode_field == MODE_FDX);
  assign serial_irq = irq_q;

endmodule : ssfd_top

//--- ssfd_top_test.sv
// bench for ssfd_top with AXI4-Lite master and serial peer.
// assumes the package, design, peer and checker are compiled.
`timescale 1ns/100ps
module ssfd_top_test;
  import ssfd_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [3:0] awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0000_0000;
  logic awr, wr_r, bv, arr, rv, sco, scoe, sck, si, so, irq, pld = 1'b0, pgo = 1'b0, pbusy;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rd, v;
  logic [7:0] ptx = 8'h00, prx, t1, p1;
  int failures = 0, checks_done = 0, seed = 47, n;
  always #50 aclk = ~aclk;
  ssfd_top dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .serial_clock_pin_i(sck), .serial_clock_pin_o(sco), .serial_clock_pin_oe(scoe),
    .serial_in_pin(si), .serial_out_pin(so), .serial_irq(irq));
  ssfd_peer peer (.aclk(aclk), .sclk_o(sco), .sclk_oe(scoe), .so(so), .load(pld), .tx(ptx),
    .go(pgo), .sclk(sck), .si(si), .rx(prx), .busy(pbusy));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic tb;
    @(posedge aclk);
    awa <= a; wd <= {24'h00_0000, d}; awv <= 1'b1; wv <= 1'b1; br <= 1'b1; tb = 1'b0;
    for (int i = 0; i < 100 && !tb; i++) begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
      tb = bv; rs = bresp;
      if (tb) br <= 1'b0;
    end
    if (!tb) begin failures++; results(); end
  endtask : wr
  task automatic rdr(input logic [3:0] a, output logic [31:0] d);
    logic tb;
    @(posedge aclk);
    ara <= a; arv <= 1'b1; rr <= 1'b1; tb = 1'b0;
    for (int i = 0; i < 100 && !tb; i++) begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      tb = rv; d = rd; rs = rresp;
      if (tb) rr <= 1'b0;
    end
    if (!tb) begin failures++; results(); end
  endtask : rdr
  task automatic xfer(input logic [7:0] t, input logic [7:0] p);
    @(posedge aclk); ptx <= p; pld <= 1'b1;
    @(posedge aclk); pld <= 1'b0;
    wr(OFF_DATA, t);
  endtask : xfer
  task automatic prun;
    @(posedge aclk); pgo <= 1'b1;
    @(posedge aclk); pgo <= 1'b0;
    repeat (2) @(posedge aclk);
    for (n = 0; n < 500 && pbusy !== 1'b0; n++) @(posedge aclk);
    if (n == 500) begin failures++; results(); end
    repeat (4) @(posedge aclk);
  endtask : prun
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(OFF_STAT, v); chk("stat reset", {24'h00_0000, STAT_RST}, v);
    rdr(OFF_CTRL, v); chk("ctrl reset", {24'h00_0000, CTRL_RST}, v);
    rdr(4'hc, v); chk("unmapped read", RESP_SLVERR, rs);
    wr(4'hc, 8'hff); chk("unmapped write", RESP_SLVERR, rs);
    t1 = $random(seed); p1 = $random(seed);
    xfer(t1, p1); // buffer loaded first
    wr(OFF_CTRL, 8'h4f); // mode 11 start
    rdr(OFF_STAT, v); chk("stat started", 32'h0000_0003, v & 32'h0000_0003);
    v = 32'h0000_0000;
    for (n = 0; n < 200 && v[3] !== 1'b1; n++) rdr(OFF_STAT, v);
    if (n == 200) begin failures++; results(); end
    chk("peer got byte", t1, prx);
    chk("pause flags", 32'h0000_0009, v);
    chk("paused out", 1'b1, so);
    wr(OFF_CTRL, 8'h47);
    rdr(OFF_CTRL, v); chk("locked ctrl", 32'h0000_004f, v);
    rdr(OFF_DATA, v); chk("rx byte", p1, v);
    rdr(OFF_STAT, v); chk("rx read clears", 32'h0000_0001, v);
    wr(OFF_CTRL, 8'h00);
    rdr(OFF_STAT, v); chk("forced stop", 32'h0000_0000, v);
    chk("out high", 1'b1, so);
    t1 = $random(seed); p1 = $random(seed);
    xfer(t1, p1);
    wr(OFF_CTRL, 8'hef); // peer clock
    prun();
    chk("ext peer got", t1, prx);
    rdr(OFF_DATA, v); chk("ext rx", p1, v);
    prun();
    chk("resent byte", t1, prx);
    rdr(OFF_STAT, v); chk("underrun set", 1'b1, v[5]);
    rdr(OFF_STAT, v); chk("underrun clear", 1'b0, v[5]);
    wr(OFF_CTRL, 8'heb);
    rdr(OFF_STAT, v); chk("stopped", 32'h0000_0000, v & 32'h0000_0007);
    results();
  end
endmodule : ssfd_top_test
